// ---- acb_pkg.sv ----
package acb_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int RESET_TIME_NS = 10000;
  localparam int RESET_CYCLES = (RESET_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CTRL_W = 8;
  localparam int RES_W = 10;
  localparam int POWER_HI_BIT = 7;
  localparam int POWER_LO_BIT = 6;
  localparam int ACQ_BIT = 5;
  localparam int SINGLE_BIT = 4;
  localparam int UNIPOLAR_BIT = 3;
  localparam int ADDR_MSB = 2;
  localparam int ADDR_W = 3;
  localparam int NUM_INPUTS = 8;
  localparam int HIGH_BITS_W = 2;
  localparam logic [1:0] PWR_SHUTDOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h1;
  localparam logic [1:0] PWR_INT_CLK = 2'h2;
  localparam logic [1:0] PWR_EXT_CLK = 2'h3;
  localparam logic [7:0] CTRL_RESET = 8'hC0;
  typedef enum logic [3:0] {
    ACB_RESET = 4'h1,
    ACB_ACTIVE = 4'h2,
    ACB_STANDBY = 4'h4,
    ACB_SHUTDOWN = 4'h8
  } acb_power_t;
endpackage

// ---- acb_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module acb_sync import acb_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Synchronous reset
  input wire logic clk_en, // Freezes state when low
  input wire logic [W-1:0] d, // Asynchronous input
  input wire logic [W-1:0] rst_val, // Value held during reset
  output logic [W-1:0] q // Synchronised output
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_sys) begin
    // Reset to the pin's idle level, so release cannot fake a select or a strobe
    if (!reset_n) begin
      meta_q <= rst_val;
      q <= rst_val;
    end else if (clk_en) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- acb_result_mux.sv ----
`timescale 1ns/100ps
`default_nettype none
module acb_result_mux import acb_pkg::*; (
  input wire logic [RES_W-1:0] result, // Conversion result code
  input wire logic unipolar, // Unipolar result mode
  input wire logic high_byte_select, // Selects upper result byte
  output logic [CTRL_W-1:0] byte_out // Byte presented to the bus
);
  always_comb begin
    if (!high_byte_select) begin
      byte_out = result[CTRL_W-1:0];
    end else if (unipolar) begin
      byte_out = {{(CTRL_W-HIGH_BITS_W){1'b0}}, result[RES_W-1:CTRL_W]};
    end else begin
      byte_out = {{(CTRL_W-HIGH_BITS_W){result[RES_W-1]}}, result[RES_W-1:CTRL_W]};
    end
  end
endmodule
`default_nettype wire

// ---- acb_core.sv ----
`timescale 1ns/100ps
`default_nettype none
module acb_core import acb_pkg::*; #(
  parameter int RESET_CNT = RESET_CYCLES,
  parameter int INPUTS = NUM_INPUTS
) (
  input wire logic clk_sys, // System clock, 20 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic clk_en, // Clock enable
  input wire logic chip_select_n, // Chip select pin, active low
  input wire logic store_strobe_n, // Write strobe pin, active low
  input wire logic read_strobe_n, // Read strobe pin, active low
  input wire logic high_byte_select, // Byte select pin for reads
  input wire logic ext_conv_clk, // External conversion clock pin
  input wire logic [CTRL_W-1:0] data_in, // Data bus input side
  output logic [CTRL_W-1:0] data_out, // Data bus output side
  output logic data_oe, // Data bus output enable
  input wire logic conv_busy, // Converter core is converting
  input wire logic conv_done, // Converter core finished, one pulse
  input wire logic [RES_W-1:0] conv_result, // Converter core raw code
  output logic conv_start, // Start request to converter core, one pulse
  output logic [INPUTS-1:0] pos_input_sel, // One-hot positive input select
  output logic [INPUTS-1:0] neg_input_sel, // One-hot negative input select, all zero in single-ended mode
  output logic neg_is_shared, // Negative input is the shared input
  output logic acq_external, // External acquisition mode
  output logic unipolar, // Unipolar mode
  output logic clock_external, // External conversion clock mode
  output logic conv_clk_gated, // Conversion clock after chip select gate
  output logic analog_powered, // Analog core powered
  output logic standby, // Reference held, core idle
  output logic reset_busy, // Internal reset interval running
  output logic conversion_done_n // Result ready, active low
);
  logic [4:0] pins_s;
  logic cs_n_s, wr_n_s, rd_n_s, hb_s, ck_s;
  logic [CTRL_W-1:0] data_s;
  logic [CTRL_W-1:0] ctrl_q;
  logic wr_n_q, ck_q;
  logic clock_ext_q;
  logic [RES_W-1:0] result_q;
  logic done_n_q;
  logic shutdown_pending_q;
  logic [$clog2(RESET_CNT+1)-1:0] rst_cnt_q;
  logic [CTRL_W-1:0] rd_byte;
  logic wr_rise, rd_active;
  logic [1:0] wr_code;
  acb_power_t pwr_q;

  acb_sync #(.W(5)) u_sync_ctl (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .d({chip_select_n, store_strobe_n, read_strobe_n, high_byte_select, ext_conv_clk}),
    .rst_val(5'h1F),
    .q(pins_s)
  );
  acb_sync #(.W(CTRL_W)) u_sync_data (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .d(data_in),
    .rst_val(8'h00),
    .q(data_s)
  );
  assign {cs_n_s, wr_n_s, rd_n_s, hb_s, ck_s} = pins_s;

  // Strobe edge only counts while selected; deselect hides the strobe entirely
  assign wr_rise = !cs_n_s && wr_n_s && !wr_n_q;
  assign rd_active = !cs_n_s && !rd_n_s;
  // Power field of the byte being written; the state machine and the checks share it
  assign wr_code = {data_s[POWER_HI_BIT], data_s[POWER_LO_BIT]};

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_n_q <= 1'b1;
      ck_q <= 1'b0;
    end else if (clk_en) begin
      wr_n_q <= cs_n_s ? 1'b1 : wr_n_s;
      ck_q <= ck_s;
    end
  end

  // Control byte latched at the end of the write strobe
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (clk_en && wr_rise && pwr_q != ACB_RESET) begin
      ctrl_q <= data_s;
    end
  end

  // Clock mode changes only on normal-operation codes
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      clock_ext_q <= 1'b1;
    end else if (clk_en && wr_rise && pwr_q != ACB_RESET && data_s[POWER_HI_BIT]) begin
      clock_ext_q <= data_s[POWER_LO_BIT];
    end
  end

  // Power state machine
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pwr_q <= ACB_RESET;
      rst_cnt_q <= '0;
      shutdown_pending_q <= 1'b0;
    end else if (clk_en) begin
      case (pwr_q)
        ACB_RESET: begin
          if (rst_cnt_q == RESET_CNT[$bits(rst_cnt_q)-1:0] - 1'b1) begin
            pwr_q <= ACB_ACTIVE;
          end else begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
          end
        end
        ACB_ACTIVE: begin
          if (wr_rise) begin
            case (wr_code)
              PWR_STANDBY: pwr_q <= ACB_STANDBY;
              PWR_SHUTDOWN: begin
                if (conv_busy) begin
                  shutdown_pending_q <= 1'b1;
                end else begin
                  pwr_q <= ACB_SHUTDOWN;
                end
              end
              default: shutdown_pending_q <= 1'b0;
            endcase
          end else if (shutdown_pending_q && !conv_busy) begin
            shutdown_pending_q <= 1'b0;
            pwr_q <= ACB_SHUTDOWN;
          end
        end
        ACB_STANDBY: begin
          if (wr_rise) begin
            pwr_q <= ACB_ACTIVE;
          end
        end
        ACB_SHUTDOWN: begin
          if (wr_rise) begin
            pwr_q <= ACB_ACTIVE;
          end
        end
        default: pwr_q <= ACB_RESET;
      endcase
    end
  end

  // Conversion only from normal operation; power-down codes still latch the byte
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      conv_start <= 1'b0;
    end else if (clk_en) begin
      conv_start <= wr_rise && pwr_q == ACB_ACTIVE && data_s[POWER_HI_BIT];
    end
  end

  // Result capture; the core delivers the code already in the selected format
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      result_q <= '0;
      done_n_q <= 1'b1;
    end else if (clk_en) begin
      if (conv_done) begin
        result_q <= conv_result;
        done_n_q <= 1'b0;
      end else if (rd_active || wr_rise) begin
        done_n_q <= 1'b1;
      end
    end
  end

  acb_result_mux u_mux (
    .result(result_q),
    .unipolar(ctrl_q[UNIPOLAR_BIT]),
    .high_byte_select(hb_s),
    .byte_out(rd_byte)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      data_out <= '0;
      data_oe <= 1'b0;
    end else if (clk_en) begin
      data_out <= rd_byte;
      data_oe <= rd_active;
    end
  end

  function automatic logic [INPUTS-1:0] onehot(input logic [ADDR_W-1:0] a);
    logic [INPUTS-1:0] v;
    v = '0;
    v[a] = 1'b1;
    return v;
  endfunction

  logic [ADDR_W-1:0] addr;
  assign addr = ctrl_q[ADDR_MSB -: ADDR_W];
  always_comb begin
    pos_input_sel = onehot(addr);
    if (ctrl_q[SINGLE_BIT]) begin
      neg_input_sel = '0;
      neg_is_shared = 1'b1;
    end else begin
      neg_input_sel = onehot(addr ^ 3'h1);
      neg_is_shared = 1'b0;
    end
  end

  assign acq_external = ctrl_q[ACQ_BIT];
  assign unipolar = ctrl_q[UNIPOLAR_BIT];
  assign clock_external = clock_ext_q;
  assign conv_clk_gated = ck_q && !cs_n_s;
  assign analog_powered = pwr_q == ACB_ACTIVE;
  assign standby = pwr_q == ACB_STANDBY;
  assign reset_busy = pwr_q == ACB_RESET;
  assign conversion_done_n = done_n_q;

  a_reset_clock_ext: assert property (@(posedge clk_sys)
    $rose(reset_n) |-> clock_external && conversion_done_n)
    else $error("reset did not select external clock");
  a_reset_length: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(reset_n) |-> reset_busy)
    else $error("reset interval skipped");
  a_no_conv_down: assert property (@(posedge clk_sys) disable iff (!reset_n)
    conv_start |-> $past(pwr_q) == ACB_ACTIVE)
    else $error("conversion started while powered down");
  a_standby_wake: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && standby && wr_rise) |=> analog_powered)
    else $error("standby did not wake");
  a_shutdown_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (pwr_q == ACB_SHUTDOWN && $past(pwr_q) == ACB_ACTIVE) |-> !$past(conv_busy))
    else $error("shutdown during conversion");
  a_shutdown_exit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && pwr_q == ACB_SHUTDOWN && wr_rise) |=> analog_powered)
    else $error("shutdown did not exit");
  a_deselect_float: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && cs_n_s) |=> !data_oe)
    else $error("bus driven while deselected");
  a_byte_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && wr_rise && !reset_busy) |=> ctrl_q == $past(data_s))
    else $error("control byte not latched");
  a_high_byte: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && hb_s && unipolar && $stable(hb_s)) |=> data_out[CTRL_W-1:HIGH_BITS_W] == 6'h00)
    else $error("unipolar high byte not zero filled");

  // Steps of a write or a selected read as the control logic sees them; the checks below build on them
  sequence s_normal_write;
    clk_en && wr_rise && analog_powered && data_s[POWER_HI_BIT];
  endsequence

  sequence s_powerdown_write;
    clk_en && wr_rise && !reset_busy && !data_s[POWER_HI_BIT];
  endsequence

  sequence s_standby_write;
    clk_en && wr_rise && analog_powered && wr_code == PWR_STANDBY;
  endsequence

  // A busy core must keep power even though the byte asks for shutdown
  sequence s_shutdown_busy;
    clk_en && wr_rise && analog_powered && wr_code == PWR_SHUTDOWN && conv_busy;
  endsequence

  sequence s_read_selected;
    clk_en && rd_active;
  endsequence

  a_normal_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_normal_write |=> conv_start)
    else $error("normal write did not start a conversion");
  a_clock_mode_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_normal_write |=> clock_external == $past(data_s[POWER_LO_BIT]))
    else $error("normal write did not set clock mode");
  a_powerdown_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_powerdown_write |=> !conv_start)
    else $error("power-down write started a conversion");
  a_clock_kept: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_powerdown_write |=> $stable(clock_external))
    else $error("power-down write changed clock mode");
  a_standby_enter: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_standby_write |=> standby)
    else $error("standby code not taken");
  a_shutdown_defer: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_shutdown_busy |=> analog_powered)
    else $error("shutdown cut a running conversion");
  a_read_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_read_selected |=> data_oe)
    else $error("selected read did not drive the bus");
  a_single_shared: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ctrl_q[SINGLE_BIT] |-> neg_is_shared && neg_input_sel == '0 && $onehot(pos_input_sel))
    else $error("single-ended input select wrong");
  a_pair_select: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !ctrl_q[SINGLE_BIT] |-> !neg_is_shared && $onehot(neg_input_sel)
      && (pos_input_sel & neg_input_sel) == '0)
    else $error("pseudo-differential pair wrong");
  a_result_capture: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && conv_done) |=> result_q == $past(conv_result))
    else $error("result not captured");
endmodule
`default_nettype wire

// ---- acb_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module acb_host_model import acb_pkg::*; (
  input wire logic clk_sys, // Clock
  output logic chip_select_n, // Select
  output logic store_strobe_n, // Write strobe
  output logic read_strobe_n, // Read strobe
  output logic high_byte_select, // Byte pick
  output logic host_oe, // Host drives bus
  output logic [CTRL_W-1:0] host_d, // Host value
  input wire logic [CTRL_W-1:0] bus // Resolved bus
);
  initial begin
    chip_select_n = 1'b1;
    store_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    high_byte_select = 1'b0;
    host_oe = 1'b0;
    host_d = 8'h00;
  end
  // Four cycles per phase so the device's two-flop sync sees every edge
  task automatic write_byte(input logic [CTRL_W-1:0] b, input logic sel);
    @(negedge clk_sys);
    chip_select_n = ~sel;
    store_strobe_n = 1'b0;
    host_oe = 1'b1;
    host_d = b;
    repeat (4) @(negedge clk_sys);
    store_strobe_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chip_select_n = 1'b1;
    host_oe = 1'b0;
  endtask
  task automatic read_byte(input logic hb, output logic [CTRL_W-1:0] v);
    @(negedge clk_sys);
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
    high_byte_select = hb;
    repeat (5) @(negedge clk_sys);
    v = bus;
    read_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ---- adc_control_byte_interface_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_control_byte_interface_tb_top import acb_pkg::*; ;
  logic clk_sys = 0, reset_n = 0, ext_conv_clk = 0, conv_busy = 0, conv_done = 0;
  logic [RES_W-1:0] conv_result = 0;
  logic cs_n, wr_n, rd_n, hbs, host_oe, data_oe, conv_start, neg_is_shared, acq_external;
  logic unipolar, clock_external, conv_clk_gated, analog_powered, standby, reset_busy;
  logic conversion_done_n;
  logic [CTRL_W-1:0] host_d, bus, data_out;
  logic [NUM_INPUTS-1:0] pos_sel, neg_sel;
  int fails = 0, num_checks = 0, seed = 39958, busy_cnt = 0, hold_len = 3, gated_seen = 0;
  // External reference assumed: 50 us of settling before the first conversion
  localparam int EXT_REF_SETTLE = 50 * (CLK_HZ / 1000000);
  // Released bus shows the inverse so a missed drive cannot match
  assign bus = data_oe ? data_out : (host_oe ? host_d : ~data_out);
  initial forever #25 clk_sys = ~clk_sys;
  acb_host_model i_acb_host_model (.clk_sys(clk_sys), .chip_select_n(cs_n),
    .store_strobe_n(wr_n), .read_strobe_n(rd_n), .high_byte_select(hbs),
    .host_oe(host_oe), .host_d(host_d), .bus(bus));
  acb_core #(.RESET_CNT(4)) i_acb_core (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(1'b1), .chip_select_n(cs_n), .store_strobe_n(wr_n), .read_strobe_n(rd_n),
    .high_byte_select(hbs), .ext_conv_clk(ext_conv_clk), .data_in(bus),
    .data_out(data_out), .data_oe(data_oe), .conv_busy(conv_busy), .conv_done(conv_done),
    .conv_result(conv_result), .conv_start(conv_start), .pos_input_sel(pos_sel),
    .neg_input_sel(neg_sel), .neg_is_shared(neg_is_shared), .acq_external(acq_external),
    .unipolar(unipolar), .clock_external(clock_external), .conv_clk_gated(conv_clk_gated),
    .analog_powered(analog_powered), .standby(standby), .reset_busy(reset_busy),
    .conversion_done_n(conversion_done_n));
  always @(negedge clk_sys) begin
    conv_done <= 1'b0;
    ext_conv_clk <= ~ext_conv_clk;
    if (conv_clk_gated === 1'b1) gated_seen <= gated_seen + 1;
    if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1) begin
        conv_busy <= 1'b0;
        conv_done <= 1'b1;
      end
    end else if (conv_start === 1'b1) begin
      busy_cnt <= hold_len;
      conv_busy <= 1'b1;
      conv_result <= RES_W'($random(seed));
    end
  end
  function automatic logic [7:0] exp_byte(input logic uni, input logic hb);
    if (!hb) return conv_result[7:0];
    return {{6{~uni & conv_result[9]}}, conv_result[9:8]};
  endfunction
  task automatic wrap_up;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (conversion_done_n !== 1'b0 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    if (conversion_done_n !== 1'b0) begin
      chk("conversion_done_n", 8'h00, 8'h01);
      wrap_up();
    end
  endtask
  initial begin
    repeat (20000) @(negedge clk_sys);
    chk("run length", 8'h00, 8'h01);
    wrap_up();
  end
  initial begin
    logic [7:0] b, v;
    repeat (2) @(negedge clk_sys);
    chk("conversion_done_n", 8'h01, {7'h0, conversion_done_n});
    chk("clock_external", 8'h01, {7'h0, clock_external});
    chk("data_oe", 8'h00, {7'h0, data_oe});
    reset_n = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk("reset_busy", 8'h00, {7'h0, reset_busy});
    repeat (EXT_REF_SETTLE) @(negedge clk_sys);
    for (int i = 0; i < 16; i++) begin
      b = {2'h3, 1'($random(seed)), i[3], 1'($random(seed)), i[2:0]};
      i_acb_host_model.write_byte(b, 1'b1);
      wait_done();
      chk("pos_input_sel", 8'h01 << i[2:0], pos_sel);
      chk("neg_input_sel", i[3] ? 8'h00 : 8'h01 << (i[2:0] ^ 3'h1), neg_sel);
      chk("mode flags", {4'h0, i[3], b[5], b[3], 1'b1},
        {4'h0, neg_is_shared, acq_external, unipolar, clock_external});
      i_acb_host_model.read_byte(1'b0, v);
      chk("low byte", exp_byte(b[3], 1'b0), v);
      i_acb_host_model.read_byte(1'b1, v);
      chk("high byte", exp_byte(b[3], 1'b1), v);
    end
    i_acb_host_model.write_byte(8'h9A, 1'b1);
    wait_done();
    chk("clock_external", 8'h00, {7'h0, clock_external});
    i_acb_host_model.write_byte(8'h40, 1'b1);
    repeat (4) @(negedge clk_sys);
    chk("standby", 8'h01, {7'h0, standby});
    chk("clock_external", 8'h00, {7'h0, clock_external});
    i_acb_host_model.read_byte(1'b0, v);
    chk("standby read", conv_result[7:0], v);
    i_acb_host_model.write_byte(8'hD8, 1'b1);
    repeat (2) @(negedge clk_sys);
    chk("wake", 8'h03, {6'h0, analog_powered, ~standby});
    hold_len = 40;
    i_acb_host_model.write_byte(8'hC8, 1'b1);
    i_acb_host_model.write_byte(8'h00, 1'b1);
    chk("powered while busy", 8'h01, {7'h0, analog_powered});
    for (int n = 0; n < 60 && conv_busy; n++) @(negedge clk_sys);
    if (conv_busy !== 1'b0) begin
      chk("conv_busy", 8'h00, 8'h01);
      wrap_up();
    end
    repeat (4) @(negedge clk_sys);
    chk("shutdown", 8'h00, {7'h0, analog_powered});
    hold_len = 3;
    i_acb_host_model.write_byte(8'hC8, 1'b1);
    repeat (2) @(negedge clk_sys);
    chk("exit shutdown", 8'h01, {7'h0, analog_powered});
    i_acb_host_model.write_byte(8'h80, 1'b0);
    chk("deselected", 8'h04, {5'h0, clock_external, data_oe, conv_clk_gated});
    chk("conv_clk_gated", 8'h01, {7'h0, gated_seen > 0});
    wrap_up();
  end
endmodule
`default_nettype wire
